// ---- pkg/tatl_defines.svh ----
// Constants for the temperature trip limit bank: offsets, field layout, resets, hysteresis.
// Assumes it is included by its bare name from every design file that needs it.
// Notes on behaviour
// - Upper limit is a 16-bit read/write register at 02h, quarter-degree steps.
// - Enabled alert asserts above upper limit, releases at upper minus hysteresis.
// - Upper limit is read-only while the window lock bit is one.
// - Upper limit bits 15:13 and 1:0 read zero; bit 12 sign; 11:2 value.
// - Lower limit is a 16-bit read/write register at 03h, quarter-degree steps.
// - Enabled alert asserts below lower minus hysteresis, releases at or above lower.
// - Lower limit is read-only while the window lock bit is one.
// - Lower limit bits 15:13 and 1:0 read zero; bit 12 sign; 11:2 value.
// - Critical limit is a 16-bit read/write register at 04h, quarter-degree steps.
// - Alert asserts above critical limit, holds until critical minus hysteresis.
// - Critical limit is read-only while the critical lock bit is one.
// - Critical limit bits 15:13 and 1:0 read zero; bit 12 sign; 11:2 value.
// - Critical-only mode asserts alert for the critical condition alone.
// - Alert output is never driven while alert enable is zero, the reset default; here it drops one edge after enable goes to zero.
// - Critical lock bit, once set, stays one until power-on reset.
`ifndef TATL_DEFINES_SVH
`define TATL_DEFINES_SVH

`define TATL_ADDR_UPPER 8'h02
`define TATL_ADDR_LOWER 8'h03
`define TATL_ADDR_CRIT 8'h04
`define TATL_FIELD_MSB 12
`define TATL_FIELD_LSB 2
`define TATL_FIELD_W 11
`define TATL_LIMIT_RST 11'h000
`define TATL_RDATA_RST 16'h0000
`define TATL_HYST_OFF 6'h00
`define TATL_HYST_1P5 6'h06
`define TATL_HYST_3P0 6'h0c
`define TATL_HYST_6P0 6'h18
`define TATL_HYST_W 6

`endif

// ---- pkg/tatl_pkg.sv ----
// Types shared by the temperature trip limit bank.
// Assumes the defines header is compiled alongside it.
`default_nettype none
package tatl_pkg;

	// Alert output state: quiet, window trip, or critical trip.
	typedef enum logic [1:0] {
		TATL_ALERT_IDLE = 2'b00,
		TATL_ALERT_WINDOW = 2'b01,
		TATL_ALERT_CRIT = 2'b10
	} tatl_alert_state_t;

	// Temperature or limit at quarter-degree steps, two's complement.
	typedef logic signed [10:0] tatl_temp_t;

endpackage : tatl_pkg
`default_nettype wire

// ---- hw/tatl_limit_reg.sv ----
// One lockable trip limit register holding the sign and value bits only.
// Assumes write strobes and address come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "tatl_defines.svh"

module tatl_limit_reg #(
	parameter logic [7:0] ADDR = `TATL_ADDR_UPPER
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic wr_in,
	input wire logic [7:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic lock_in,
	output logic [10:0] field_out,
	output logic dropped_out
);

	logic [10:0] field_q;
	logic [10:0] field_d;
	logic hit;

	// Only bits 12:2 are stored, so reserved bits can never read back non-zero.
	always_comb begin
		hit = wr_in && (addr_in == ADDR);
		field_d = field_q;
		if (hit && !lock_in) begin
			field_d = wdata_in[`TATL_FIELD_MSB:`TATL_FIELD_LSB];
		end
		dropped_out = hit && lock_in;
	end

	// Register stage.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			field_q <= `TATL_LIMIT_RST;
		end else begin
			field_q <= field_d;
		end
	end

	assign field_out = field_q;

endmodule : tatl_limit_reg
`default_nettype wire

// ---- hw/tatl_compare.sv ----
// One limit comparator with hysteresis, updated on each new temperature result.
// Assumes temperature and limit are quarter-degree signed values on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "tatl_defines.svh"

module tatl_compare #(
	parameter bit LOWER = 1'b0
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic valid_in,
	input wire logic [10:0] temp_in,
	input wire logic [10:0] limit_in,
	input wire logic [5:0] hyst_in,
	output logic flag_out
);

	logic flag_q;
	logic flag_d;
	logic signed [12:0] t;
	logic signed [12:0] lim;
	logic signed [12:0] lim_h;

	// Sign-extends to 13 bits so limit minus hysteresis can never wrap.
	function automatic logic signed [12:0] tatl_sext(input logic [10:0] v);
		tatl_sext = signed'({{2{v[10]}}, v});
	endfunction : tatl_sext

	// Set and release thresholds differ by the hysteresis, so a noisy reading near a limit
	// does not chatter the flag.
	always_comb begin
		t = tatl_sext(temp_in);
		lim = tatl_sext(limit_in);
		lim_h = lim - signed'({7'h00, hyst_in});
		flag_d = flag_q;
		if (valid_in) begin
			if (LOWER) begin
				if (t < lim_h) begin
					flag_d = 1'b1;
				end else if (t >= lim) begin
					flag_d = 1'b0;
				end
			end else begin
				if (t > lim) begin
					flag_d = 1'b1;
				end else if (t <= lim_h) begin
					flag_d = 1'b0;
				end
			end
		end
	end

	// Register stage.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	assign flag_out = flag_q;

endmodule : tatl_compare
`default_nettype wire

// ---- hw/tatl_top.sv ----
// Trip limit bank: three lockable limits, comparators and the alert output.
// Assumes the serial engine drives the register port and the converter the temperature,
// both on clk_in; configuration bits arrive as plain inputs from the same clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "tatl_defines.svh"

module tatl_top (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	output logic [15:0] reg_rdata_out,
	output logic reg_ack_out,
	input wire logic window_lock_in,
	input wire logic critical_lock_in,
	input wire logic alert_enable_in,
	input wire logic critical_only_in,
	input wire logic [1:0] hyst_sel_in,
	input wire logic [15:0] temp_in,
	input wire logic temp_valid_in,
	output logic alert_out,
	output logic upper_flag_out,
	output logic lower_flag_out,
	output logic crit_flag_out,
	output logic window_lock_out,
	output logic critical_lock_out,
	output logic write_dropped_out
);

	logic [10:0] upper_limit_field;
	logic [10:0] lower_limit_field;
	logic [10:0] critical_limit_field;
	logic upper_drop;
	logic lower_drop;
	logic crit_drop;
	logic upper_hit;
	logic lower_hit;
	logic crit_hit;
	logic [5:0] hyst;
	logic [10:0] temp_q;
	logic [10:0] temp_d;
	logic temp_valid_q;
	logic temp_valid_d;

	logic window_lock_bit_q;
	logic window_lock_bit_d;
	logic critical_lock_bit_q;
	logic critical_lock_bit_d;

	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic ack_q;
	logic ack_d;
	logic dropped_q;
	logic dropped_d;

	tatl_pkg::tatl_alert_state_t state_q;
	tatl_pkg::tatl_alert_state_t state_d;
	logic alert_q;
	logic alert_d;
	logic upper_q;
	logic upper_d;
	logic lower_q;
	logic lower_d;
	logic crit_q;
	logic crit_d;

	// Places a stored limit back into its 16-bit register image with zeros around it.
	function automatic logic [15:0] tatl_pack(input logic [10:0] field);
		tatl_pack = {3'h0, field, 2'h0};
	endfunction : tatl_pack

	// Maps the hysteresis selection to quarter-degree steps.
	function automatic logic [5:0] tatl_hyst(input logic [1:0] sel);
		case (sel)
			2'h0: tatl_hyst = `TATL_HYST_OFF;
			2'h1: tatl_hyst = `TATL_HYST_1P5;
			2'h2: tatl_hyst = `TATL_HYST_3P0;
			default: tatl_hyst = `TATL_HYST_6P0;
		endcase
	endfunction : tatl_hyst

	// Lock bits only ever set; nothing but the reset clears them, so software
	// cannot unlock a limit once it has been frozen.
	always_comb begin
		window_lock_bit_d = window_lock_bit_q | window_lock_in;
		critical_lock_bit_d = critical_lock_bit_q | critical_lock_in;
	end

	// Register stage for the lock bits.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			window_lock_bit_q <= 1'b0;
			critical_lock_bit_q <= 1'b0;
		end else begin
			window_lock_bit_q <= window_lock_bit_d;
			critical_lock_bit_q <= critical_lock_bit_d;
		end
	end

	// Upper limit, frozen by the window lock.
	tatl_limit_reg #(
		.ADDR(`TATL_ADDR_UPPER)
	) u_upper (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.wr_in(reg_wr_in),
		.addr_in(reg_addr_in),
		.wdata_in(reg_wdata_in),
		.lock_in(window_lock_bit_q),
		.field_out(upper_limit_field),
		.dropped_out(upper_drop)
	);

	// Lower limit, frozen by the same window lock.
	tatl_limit_reg #(
		.ADDR(`TATL_ADDR_LOWER)
	) u_lower (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.wr_in(reg_wr_in),
		.addr_in(reg_addr_in),
		.wdata_in(reg_wdata_in),
		.lock_in(window_lock_bit_q),
		.field_out(lower_limit_field),
		.dropped_out(lower_drop)
	);

	// Critical limit, frozen by its own lock.
	tatl_limit_reg #(
		.ADDR(`TATL_ADDR_CRIT)
	) u_crit (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.wr_in(reg_wr_in),
		.addr_in(reg_addr_in),
		.wdata_in(reg_wdata_in),
		.lock_in(critical_lock_bit_q),
		.field_out(critical_limit_field),
		.dropped_out(crit_drop)
	);

	// Read mux and acknowledge; every access is acknowledged one cycle later,
	// including a dropped write and an unmapped address, which reads zero.
	always_comb begin
		rdata_d = rdata_q;
		ack_d = reg_rd_in | reg_wr_in;
		dropped_d = upper_drop | lower_drop | crit_drop;
		if (reg_rd_in) begin
			case (reg_addr_in)
				`TATL_ADDR_UPPER: rdata_d = tatl_pack(upper_limit_field);
				`TATL_ADDR_LOWER: rdata_d = tatl_pack(lower_limit_field);
				`TATL_ADDR_CRIT: rdata_d = tatl_pack(critical_limit_field);
				default: rdata_d = `TATL_RDATA_RST;
			endcase
		end
	end

	// Register stage for the register port.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_q <= `TATL_RDATA_RST;
			ack_q <= 1'b0;
			dropped_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			ack_q <= ack_d;
			dropped_q <= dropped_d;
		end
	end

	// Capture each result with its two bits below a quarter degree dropped, so the compare runs at
	// the limits' resolution and a half-step reading cannot flip a flag.
	always_comb begin
		temp_valid_d = temp_valid_in;
		temp_d = temp_valid_in ? temp_in[`TATL_FIELD_MSB:`TATL_FIELD_LSB] : temp_q;
		hyst = tatl_hyst(hyst_sel_in);
	end

	// Register stage for the temperature capture.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			temp_q <= `TATL_LIMIT_RST;
			temp_valid_q <= 1'b0;
		end else begin
			temp_q <= temp_d;
			temp_valid_q <= temp_valid_d;
		end
	end

	// Upper window comparator.
	tatl_compare #(
		.LOWER(1'b0)
	) u_cmp_upper (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.valid_in(temp_valid_q),
		.temp_in(temp_q),
		.limit_in(upper_limit_field),
		.hyst_in(hyst),
		.flag_out(upper_hit)
	);

	// Lower window comparator.
	tatl_compare #(
		.LOWER(1'b1)
	) u_cmp_lower (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.valid_in(temp_valid_q),
		.temp_in(temp_q),
		.limit_in(lower_limit_field),
		.hyst_in(hyst),
		.flag_out(lower_hit)
	);

	// Critical comparator.
	tatl_compare #(
		.LOWER(1'b0)
	) u_cmp_crit (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.valid_in(temp_valid_q),
		.temp_in(temp_q),
		.limit_in(critical_limit_field),
		.hyst_in(hyst),
		.flag_out(crit_hit)
	);

	// Alert state: critical outranks the window, and the enable gates the alert but not the flags,
	// so disabling the output releases it at the next edge even while a trip persists.
	always_comb begin
		upper_d = upper_hit;
		lower_d = lower_hit;
		crit_d = crit_hit;
		state_d = tatl_pkg::TATL_ALERT_IDLE;
		case (state_q)
			tatl_pkg::TATL_ALERT_IDLE,
			tatl_pkg::TATL_ALERT_WINDOW,
			tatl_pkg::TATL_ALERT_CRIT: begin
				if (!alert_enable_in) begin
					state_d = tatl_pkg::TATL_ALERT_IDLE;
				end else if (crit_hit) begin
					state_d = tatl_pkg::TATL_ALERT_CRIT;
				end else if (!critical_only_in && (upper_hit || lower_hit)) begin
					state_d = tatl_pkg::TATL_ALERT_WINDOW;
				end else begin
					state_d = tatl_pkg::TATL_ALERT_IDLE;
				end
			end
			default: begin
				state_d = tatl_pkg::TATL_ALERT_IDLE;
			end
		endcase
		alert_d = (state_d != tatl_pkg::TATL_ALERT_IDLE);
	end

	// Register stage for the alert and the trip flags.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= tatl_pkg::TATL_ALERT_IDLE;
			alert_q <= 1'b0;
			upper_q <= 1'b0;
			lower_q <= 1'b0;
			crit_q <= 1'b0;
		end else begin
			state_q <= state_d;
			alert_q <= alert_d;
			upper_q <= upper_d;
			lower_q <= lower_d;
			crit_q <= crit_d;
		end
	end

	// Outputs, all straight from flip-flops.
	assign reg_rdata_out = rdata_q;
	assign reg_ack_out = ack_q;
	assign alert_out = alert_q;
	assign upper_flag_out = upper_q;
	assign lower_flag_out = lower_q;
	assign crit_flag_out = crit_q;
	assign window_lock_out = window_lock_bit_q;
	assign critical_lock_out = critical_lock_bit_q;
	assign write_dropped_out = dropped_q;

endmodule : tatl_top
`default_nettype wire

// ---- dv/tatl_top_assertions.sv ----
// Checker for the trip limit bank, watching the top module's ports only.
// Assumes one clock domain and the asynchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module tatl_top_assertions (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic reg_ack_out,
	input wire logic alert_enable_in,
	input wire logic critical_only_in,
	input wire logic temp_valid_in,
	input wire logic alert_out,
	input wire logic upper_flag_out,
	input wire logic lower_flag_out,
	input wire logic crit_flag_out,
	input wire logic window_lock_out,
	input wire logic critical_lock_out,
	input wire logic write_dropped_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// Steps of a register access, plain and against a locked limit.
	sequence s_access;
		reg_rd_in || reg_wr_in;
	endsequence
	sequence s_win_wr;
		reg_wr_in && (reg_addr_in == 8'h02 || reg_addr_in == 8'h03) && window_lock_out;
	endsequence
	sequence s_crit_wr;
		reg_wr_in && reg_addr_in == 8'h04 && critical_lock_out;
	endsequence

	// Acknowledge timing, reserved bits, dropped writes and lock hold.
	ack_follows_a: assert property (s_access |=> reg_ack_out)
		else $error("Access without acknowledge.");
	ack_spurious_a: assert property (!(reg_rd_in || reg_wr_in) |=> !reg_ack_out)
		else $error("Acknowledge without access.");
	rsvd_zero_a: assert property (reg_ack_out |-> reg_rdata_out[15:13] == 3'h0 && reg_rdata_out[1:0] == 2'h0)
		else $error("Reserved read bits not zero.");
	win_drop_a: assert property (s_win_wr |=> write_dropped_out && reg_ack_out)
		else $error("Window locked write not dropped.");
	crit_drop_a: assert property (s_crit_wr |=> write_dropped_out)
		else $error("Critical locked write not dropped.");
	drop_cause_a: assert property (write_dropped_out |-> $past(reg_wr_in))
		else $error("Drop pulse without a write.");
	crit_lock_hold_a: assert property (critical_lock_out |=> critical_lock_out)
		else $error("Critical lock cleared.");
	win_lock_hold_a: assert property (window_lock_out |=> window_lock_out)
		else $error("Window lock cleared.");
	// Alert gating follows the enable one edge later.
	alert_off_a: assert property (!alert_enable_in |=> !alert_out)
		else $error("Alert while disabled.");
	// The flag outputs and the alert register from the same comparator state, so the
	// flag seen one edge after the configuration is the one that drove the alert.
	crit_only_a: assert property (critical_only_in ##1 !crit_flag_out |-> !alert_out)
		else $error("Window alert in critical-only mode.");
	crit_alert_a: assert property (alert_enable_in ##1 crit_flag_out |-> alert_out)
		else $error("Critical trip without alert.");
	// A result is captured, compared, then registered out: three edges from valid.
	flag_cause_a: assert property ($changed({upper_flag_out, lower_flag_out, crit_flag_out})
		|-> $past(temp_valid_in, 3))
		else $error("Flag moved without a result.");
endmodule : tatl_top_assertions

bind tatl_top tatl_top_assertions u_chk (.clk_in, .rst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
	.reg_rdata_out, .reg_ack_out, .alert_enable_in, .critical_only_in, .temp_valid_in,
	.alert_out, .upper_flag_out, .lower_flag_out, .crit_flag_out, .window_lock_out,
	.critical_lock_out, .write_dropped_out);

`default_nettype wire

// ---- dv/tatl_host_model.sv ----
// Host side of the register port: one strobe pulse per access.
// Assumes the caller waits for reset release before the first access.
`timescale 1ns/10ps
`default_nettype none

module tatl_host_model (
	input wire logic clk_in,
	output logic wr_out,
	output logic rd_out,
	output logic [7:0] addr_out,
	output logic [15:0] wdata_out
);
	// Idle bus at time zero.
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 8'h00;
		wdata_out = 16'h0000;
	end

	// The data bus shows the inverse once released, so stale data is never mistaken.
	task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		#1;
		wr_out = wr;
		rd_out = !wr;
		addr_out = a;
		wdata_out = d;
		@(posedge clk_in);
		#1;
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = ~d;
	endtask : access
endmodule : tatl_host_model

`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the trip limit bank with a host model on the register port.
// Assumes the bound checker and a 250 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic clk_in = 1'b0, rst_in = 1'b1, rd, wr, wl = 1'b0, cl = 1'b0, en = 1'b0, co = 1'b0;
	logic [1:0] hs = 2'h0;
	logic [15:0] tmp = 16'h0000, rdata, wd, sh [2:4];
	logic [7:0] ad;
	logic vld = 1'b0, ack, alert, uf, lf, cf, wlo, clo, drop, mu, ml, mc;
	logic [17:0] exp_q [$], e;
	int miscompares = 0, samples_checked = 0;

	tatl_host_model u_host (.clk_in(clk_in), .wr_out(wr), .rd_out(rd), .addr_out(ad),
		.wdata_out(wd));
	tatl_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_addr_in(ad), .reg_wdata_in(wd), .reg_rdata_out(rdata), .reg_ack_out(ack),
		.window_lock_in(wl), .critical_lock_in(cl), .alert_enable_in(en),
		.critical_only_in(co), .hyst_sel_in(hs), .temp_in(tmp), .temp_valid_in(vld),
		.alert_out(alert), .upper_flag_out(uf), .lower_flag_out(lf), .crit_flag_out(cf),
		.window_lock_out(wlo), .critical_lock_out(clo), .write_dropped_out(drop));

	// Free-running clock at a 4 ns period.
	always #2 clk_in = ~clk_in;

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	function automatic logic [15:0] img(input logic [15:0] d);
		return {3'h0, d[12:2], 2'h0};
	endfunction : img

	// Notes the expected answer, then lets the host make the access.
	task automatic reg_op(input logic w, input logic [7:0] a, input logic [15:0] d,
		input logic [15:0] x, input logic dr);
		exp_q.push_back({!w, dr, x});
		u_host.access(w, a, d);
	endtask : reg_op

	// Each acknowledge retires the oldest note.
	always @(posedge clk_in) begin
		if (ack === 1'b1) begin
			e = exp_q.pop_front();
			check(16'(drop), 16'(e[16]));
			if (e[17]) check(rdata, e[15:0]);
		end
	end

	// One random result, checked once flags and alert have settled.
	task automatic temp_step();
		int t, h;
		t = int'($urandom_range(220)) - 100;
		@(posedge clk_in);
		#1;
		hs = 2'($urandom);
		en = 1'($urandom);
		co = 1'($urandom);
		tmp = {3'($urandom), 11'(t), 2'($urandom)};
		vld = 1'b1;
		@(posedge clk_in);
		#1;
		vld = 1'b0;
		h = (hs == 2'h0) ? 0 : 6 << (hs - 2'h1);
		if (t > 40) mu = 1'b1; else if (t <= 40 - h) mu = 1'b0;
		if (t < -40 - h) ml = 1'b1; else if (t >= -40) ml = 1'b0;
		if (t > 80) mc = 1'b1; else if (t <= 80 - h) mc = 1'b0;
		repeat (3) @(posedge clk_in);
		#1;
		check(16'({uf, lf, cf}), 16'({mu, ml, mc}));
		check(16'(alert), 16'(en & (mc | (!co & (mu | ml)))));
	endtask : temp_step

	task automatic print_verdict();
		$display("Checked %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict

	// Watchdog well beyond the expected run length.
	initial begin
		#200000;
		miscompares++;
		print_verdict();
	end

	// Main sequence: reset values, readback, trips, locks, then a second reset.
	initial begin
		logic [15:0] w;
		void'($urandom(32'h0a4c5f80));
		{mu, ml, mc} = 3'h0;
		repeat (3) @(posedge clk_in);
		#1;
		rst_in = 1'b0;
		for (int a = 2; a <= 5; a++) reg_op(1'b0, 8'(a), 16'h0000, 16'h0000, 1'b0);
		for (int i = 0; i < 6; i++) begin
			for (int a = 2; a <= 4; a++) begin
				w = 16'($urandom);
				reg_op(1'b1, 8'(a), w, 16'h0000, 1'b0);
				reg_op(1'b0, 8'(a), 16'h0000, img(w), 1'b0);
			end
		end
		reg_op(1'b1, 8'h07, 16'hffff, 16'h0000, 1'b0);
		reg_op(1'b0, 8'h07, 16'h0000, 16'h0000, 1'b0);
		reg_op(1'b1, 8'h02, 16'h00a0, 16'h0000, 1'b0);
		reg_op(1'b1, 8'h03, 16'h1f60, 16'h0000, 1'b0);
		reg_op(1'b1, 8'h04, 16'h0140, 16'h0000, 1'b0);
		sh[2] = 16'h00a0;
		sh[3] = 16'h1f60;
		sh[4] = 16'h0140;
		repeat (60) temp_step();
		@(posedge clk_in);
		#1;
		wl = 1'b1;
		@(posedge clk_in);
		#1;
		wl = 1'b0;
		for (int a = 2; a <= 4; a++) begin
			w = 16'($urandom);
			if (a == 4) sh[4] = img(w);
			reg_op(1'b1, 8'(a), w, 16'h0000, a != 4);
			reg_op(1'b0, 8'(a), 16'h0000, sh[a], 1'b0);
		end
		@(posedge clk_in);
		#1;
		cl = 1'b1;
		@(posedge clk_in);
		#1;
		cl = 1'b0;
		reg_op(1'b1, 8'h04, 16'h1234, 16'h0000, 1'b1);
		reg_op(1'b0, 8'h04, 16'h0000, sh[4], 1'b0);
		check({14'h0, wlo, clo}, 16'h0003);
		// Let the last acknowledge retire its note before reset swallows it.
		@(posedge clk_in);
		#1;
		rst_in = 1'b1;
		repeat (3) @(posedge clk_in);
		#1;
		rst_in = 1'b0;
		check({14'h0, wlo, clo}, 16'h0000);
		reg_op(1'b0, 8'h04, 16'h0000, 16'h0000, 1'b0);
		repeat (4) @(posedge clk_in);
		#1;
		// A note still queued means an access was never acknowledged.
		check(16'(exp_q.size()), 16'h0000);
		print_verdict();
	end
endmodule : tb

`default_nettype wire
